/* File: hw/swio_pkg.sv */
// Purpose: shared constants and types for the switching i/o and display hold block
// Assumes: 25 MHz system clock, signed 32-bit measured values
// Notes: register map, field positions, reset values and timing counts live here
package swio_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MIN_PULSE_MS = 180;
  localparam int unsigned MIN_PULSE_CYC = (CLK_HZ / 1000) * MIN_PULSE_MS;
  localparam int unsigned MS_PER_MIN = 60_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned IDLE_MIN_LO = 30;
  localparam int unsigned IDLE_MIN_HI = 120;

  // capacities
  localparam int unsigned SERIES_MAX = 10000;
  localparam int unsigned SPC_MAX = 1000;

  // register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LIMIT_HI = 4'h1;
  localparam logic [3:0] REG_LIMIT_LO = 4'h2;
  localparam logic [3:0] REG_IDLE = 4'h3;
  localparam logic [3:0] REG_DTG_OUT = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_SHOWN = 4'h7;
  localparam logic [3:0] REG_SERIES = 4'h8;
  localparam logic [3:0] REG_SPC = 4'h9;

  // ctrl fields
  localparam int CTRL_THR_EN = 0;
  localparam int CTRL_DTG = 1;
  localparam int CTRL_HOLD_LSB = 2;  // 2 bits
  localparam int CTRL_VER2 = 4;
  localparam int CTRL_LOCAL_VIEW_LSB = 5;  // 2 bits
  localparam int CTRL_REC_SRC_LSB = 7;  // 2 bits
  localparam int CTRL_REC_EN = 9;
  localparam int CTRL_SPC_EN = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  localparam logic [6:0] IDLE_RESET = 7'h1E;

  // cmd fields (write-one pulses)
  localparam int CMD_PRINT = 0;
  localparam int CMD_FAULT_ACK = 1;
  localparam int CMD_BLANK_OFF = 2;
  localparam int CMD_REC_KEY = 3;
  localparam int CMD_SERIES_CLR = 4;
  localparam logic [6:0] ASCII_CTRL_B = 7'h02;

  typedef enum logic [1:0] {
    HOLD_CONCURRENT, HOLD_FROZEN_CONC, HOLD_FROZEN
  } hold_mode_t;

  typedef enum logic [2:0] {
    VIEW_LIVE, VIEW_MIN, VIEW_MAX, VIEW_RANGE,
    VIEW_AXIS1, VIEW_AXIS2, VIEW_SUM, VIEW_RANGE_VIEW
  } view_t;

  typedef enum logic [1:0] { REC_TIMER, REC_EXTERNAL, REC_KEY } rec_src_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // switching outputs toward the connector
  typedef struct packed {
    logic at_or_above_limit;
    logic at_or_below_limit;
    logic zero;
    logic fault;
  } sw_out_t;

  // switching inputs on the connector (five select pins)
  typedef struct packed {
    logic pin5;
    logic pin6_n;
    logic pin7;
    logic pin8;
    logic pin9;
    logic latch;
    logic rec_ext;
  } sw_in_t;

endpackage : swio_pkg

/* File: hw/swio_display_hold.sv */
// Operation
// - blank display after 30..120 idle minutes
// - blanking disable lasts until next reset
// - global enable gates both threshold outputs
// - upper output while value at/above limit
// - lower output while value at/below limit
// - zero output when shown value is zero
// - every switching output lasts at least 180 ms
// - fault output held until acknowledged
// - distance-to-go replaces threshold output function
// - output event from pin, ctrl-b, print
// - concurrent hold keeps display tracking live
// - frozen/concurrent holds while input stays asserted
// - frozen hold refreshes only on output event
// - version one control needs pin6 low
// - one select pin picks min/max/range
// - zero or several selects give live view
// - series-start pulse gated by pin6 low
// - version two selects two-axis views
// - series storage capped at 10000 per axis
// - recording by key, external or timer
// - statistical control fifo holds 1000 values
//
// Purpose: switching inputs/outputs, display hold and view selection
// Assumes: inputs synchronous to clk; values signed 32 bit; rx_valid one-cycle
// Notes: series and spc storage are counted here, the sample memory is outside
`timescale 1ns/100ps
module swio_display_hold #(
  parameter int unsigned MIN_PULSE = swio_pkg::MIN_PULSE_CYC,
  parameter int unsigned MS_TICK = swio_pkg::CYC_PER_MS,
  parameter int unsigned MIN_TICK = swio_pkg::MS_PER_MIN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire swio_pkg::reg_req_t req,
  output logic [31:0] rdata,
  input wire swio_pkg::sw_in_t sw_in,
  output swio_pkg::sw_out_t sw_out,
  input wire logic signed [31:0] axis1_value,
  input wire logic signed [31:0] axis2_value,
  input wire logic signed [31:0] func_value,
  input wire logic signed [31:0] live_min,
  input wire logic signed [31:0] live_max,
  input wire logic sample_valid,
  input wire logic activity,
  input wire logic fault_detect,
  input wire logic [6:0] rx_char,
  input wire logic rx_valid,
  input wire logic rec_timer_tick,
  output logic signed [31:0] shown_value,
  output logic display_on,
  output logic output_event,
  output logic series_start,
  output logic record_strobe,
  output logic spc_push
);
  import swio_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers written by software
  logic [31:0] ctrl_q;  // mode and enable bits
  logic signed [31:0] lim_hi_q;  // upper limit
  logic signed [31:0] lim_lo_q;  // lower limit
  logic [6:0] idle_q;  // idle minutes
  logic [1:0] dtg_q;  // distance-to-go output levels from outside logic
  logic blank_off_q;  // blanking disabled this power cycle

  wire wr_ctrl = req.wr && req.addr == REG_CTRL;
  wire wr_hi = req.wr && req.addr == REG_LIMIT_HI;
  wire wr_lo = req.wr && req.addr == REG_LIMIT_LO;
  wire wr_idle = req.wr && req.addr == REG_IDLE;
  wire wr_dtg = req.wr && req.addr == REG_DTG_OUT;
  wire wr_cmd = req.wr && req.addr == REG_CMD;
  wire cmd_print = wr_cmd && req.wdata[CMD_PRINT];
  wire cmd_ack = wr_cmd && req.wdata[CMD_FAULT_ACK];
  wire cmd_blank_off = wr_cmd && req.wdata[CMD_BLANK_OFF];
  wire cmd_rec_key = wr_cmd && req.wdata[CMD_REC_KEY];
  wire cmd_series_clr = wr_cmd && req.wdata[CMD_SERIES_CLR];

  // clamp the whole word, cutting to 7 bits first would wrap large values
  function automatic logic [6:0] clamp_idle(input logic [31:0] m);
    if (m < 32'(IDLE_MIN_LO)) return 7'(IDLE_MIN_LO);
    if (m > 32'(IDLE_MIN_HI)) return 7'(IDLE_MIN_HI);
    return m[6:0];
  endfunction : clamp_idle

  // software register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      lim_hi_q <= LIMIT_RESET;
      lim_lo_q <= LIMIT_RESET;
      idle_q <= IDLE_RESET;
      dtg_q <= 2'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= req.wdata;
      if (wr_hi) lim_hi_q <= req.wdata;
      if (wr_lo) lim_lo_q <= req.wdata;
      if (wr_idle) idle_q <= clamp_idle(req.wdata);
      if (wr_dtg) dtg_q <= req.wdata[1:0];
    end
  end

  wire thr_en = ctrl_q[CTRL_THR_EN];
  wire dtg_mode = ctrl_q[CTRL_DTG];
  wire hold_mode_t hold = hold_mode_t'(ctrl_q[CTRL_HOLD_LSB +: 2]);
  wire ver2 = ctrl_q[CTRL_VER2];
  wire [1:0] local_view = ctrl_q[CTRL_LOCAL_VIEW_LSB +: 2];
  wire rec_src_t rec_src = rec_src_t'(ctrl_q[CTRL_REC_SRC_LSB +: 2]);
  wire rec_en = ctrl_q[CTRL_REC_EN];
  wire spc_en = ctrl_q[CTRL_SPC_EN];

  ////////////////////////////////////////////////////////////////////////
  // idle blanking
  logic [15:0] ms_cnt_q;  // cycles within a millisecond
  logic [15:0] min_ms_q;  // milliseconds within a minute
  logic [6:0] idle_min_q;  // idle minutes elapsed
  logic blank_q;  // display dark
  wire ms_tick = ms_cnt_q == 16'(MS_TICK - 1);
  wire min_tick = ms_tick && min_ms_q == 16'(MIN_TICK - 1);
  wire wake = activity || req.wr;

  // disable survives until reset, which stands for power-up
  always_ff @(posedge clk) begin
    if (!rst_n) blank_off_q <= 1'b0;
    else if (cmd_blank_off) blank_off_q <= 1'b1;
  end

  // minute counter cleared by any activity
  always_ff @(posedge clk) begin
    if (!rst_n || wake) begin
      ms_cnt_q <= 16'h0000;
      min_ms_q <= 16'h0000;
      idle_min_q <= 7'h00;
    end else begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
      if (ms_tick) min_ms_q <= (min_tick) ? 16'h0000 : min_ms_q + 16'h0001;
      if (min_tick && idle_min_q != idle_q) idle_min_q <= idle_min_q + 7'h01;
    end
  end

  // blank once the idle span is reached
  always_ff @(posedge clk) begin
    if (!rst_n || wake || blank_off_q) blank_q <= 1'b0;
    else if (idle_min_q == idle_q) blank_q <= 1'b1;
  end
  assign display_on = !blank_q;

  ////////////////////////////////////////////////////////////////////////
  // output event sources and display hold
  logic latch_d1_q;  // previous latch input level
  wire latch_rise = sw_in.latch && !latch_d1_q;
  wire ctrl_b = rx_valid && rx_char == ASCII_CTRL_B;
  wire event_now = latch_rise || ctrl_b || cmd_print;
  logic event_q;  // registered event pulse
  logic frozen_q;  // display frozen
  logic signed [31:0] held_q;  // value captured at the event
  logic signed [31:0] view_value;  // value selected for display

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_d1_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      latch_d1_q <= sw_in.latch;
      event_q <= event_now;
    end
  end
  assign output_event = event_q;

  // freeze state follows the hold mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frozen_q <= 1'b0;
      held_q <= 32'sh0000_0000;
    end else begin
      case (hold)
        HOLD_CONCURRENT: frozen_q <= 1'b0;
        HOLD_FROZEN_CONC: begin
          if (event_now) frozen_q <= 1'b1;
          else if (!sw_in.latch) frozen_q <= 1'b0;
        end
        HOLD_FROZEN: begin
          if (event_now) frozen_q <= 1'b1;
        end
        default: frozen_q <= 1'b0;
      endcase
      if (event_now) held_q <= view_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) shown_value <= 32'sh0000_0000;
    else shown_value <= frozen_q ? held_q : view_value;
  end

  ////////////////////////////////////////////////////////////////////////
  // view selection from the external inputs
  wire ext_ok = !sw_in.pin6_n;
  wire [2:0] sel = {sw_in.pin7, sw_in.pin8, sw_in.pin9};
  view_t v1_view;
  view_t v2_view;
  view_t view;

  // one-hot select decode, anything else shows live
  always_comb begin
    case (sel)
      3'b100: v1_view = VIEW_MIN;
      3'b010: v1_view = VIEW_MAX;
      3'b001: v1_view = VIEW_RANGE;
      default: v1_view = VIEW_LIVE;
    endcase
  end

  // version two: first active pin by fixed priority
  always_comb begin
    if (!sw_in.pin6_n) v2_view = VIEW_AXIS1;
    else if (sw_in.pin7) v2_view = VIEW_AXIS2;
    else if (sw_in.pin8) v2_view = VIEW_SUM;
    else if (sw_in.pin9) v2_view = VIEW_RANGE_VIEW;
    else if (sw_in.pin5) v2_view = VIEW_LIVE;
    else v2_view = VIEW_AXIS1;
  end

  // local select ignored while external control is effective
  assign view = ver2 ? v2_view : (ext_ok ? v1_view : view_t'({1'b0, local_view}));

  always_comb begin
    case (view)
      VIEW_MIN: view_value = live_min;
      VIEW_MAX: view_value = live_max;
      VIEW_RANGE: view_value = live_max - live_min;
      VIEW_AXIS1: view_value = axis1_value;
      VIEW_AXIS2: view_value = axis2_value;
      VIEW_SUM: view_value = axis1_value + axis2_value;
      VIEW_RANGE_VIEW: view_value = axis1_value - axis2_value;
      default: view_value = (ver2 && sw_in.pin5) ? func_value : axis1_value;
    endcase
  end

  // series start on a pin5 rising edge, version one only
  logic pin5_d1_q;  // previous pin5 level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin5_d1_q <= 1'b0;
      series_start <= 1'b0;
    end else begin
      pin5_d1_q <= sw_in.pin5;
      series_start <= !ver2 && ext_ok && sw_in.pin5 && !pin5_d1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // threshold, zero and fault outputs
  logic [2:0] lvl_q;  // conditions sampled per measurement
  logic fault_q;  // fault latched until acknowledged
  logic cfg_wr_q;  // ctrl or dtg write seen last cycle
  wire [3:0] raw = {lvl_q, fault_q};  // above, below, zero, fault
  wire hi_cond = thr_en && (dtg_mode ? dtg_q[1] : axis1_value >= lim_hi_q);
  wire lo_cond = thr_en && (dtg_mode ? dtg_q[0] : axis1_value <= lim_lo_q);
  wire zero_cond = shown_value == 32'sh0000_0000;

  // refresh after a ctrl or dtg write too, once the new setting has landed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q <= 3'h0;
      cfg_wr_q <= 1'b0;
    end else begin
      cfg_wr_q <= wr_ctrl || wr_dtg;
      if (sample_valid || cfg_wr_q) lvl_q <= {hi_cond, lo_cond, zero_cond};
    end
  end

  // fault latches, set beats a same-cycle acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) fault_q <= 1'b0;
    else if (fault_detect) fault_q <= 1'b1;
    else if (cmd_ack) fault_q <= 1'b0;
  end

  // minimum pulse stretch per output
  logic [22:0] pulse_cnt_q [4];  // remaining minimum hold
  logic [3:0] prev_q;  // previous raw levels
  logic [3:0] out_q;  // stretched outputs
  for (genvar i = 0; i < 4; i++) begin : g_stretch
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pulse_cnt_q[i] <= 23'h0;
        prev_q[i] <= 1'b0;
        out_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= raw[i];
        if (raw[i] && !prev_q[i]) pulse_cnt_q[i] <= 23'(MIN_PULSE - 1);
        else if (pulse_cnt_q[i] != 23'h0) pulse_cnt_q[i] <= pulse_cnt_q[i] - 23'h1;
        out_q[i] <= raw[i] || (pulse_cnt_q[i] != 23'h0);
      end
    end
  end
  assign sw_out = sw_out_t'(out_q);

  ////////////////////////////////////////////////////////////////////////
  // series recording and statistical control fill
  logic [13:0] series_cnt_q;  // values recorded per axis
  logic [9:0] spc_cnt_q;  // values held in the fifo
  logic rec_trig;  // selected record trigger
  logic rec_d1_q;  // previous external record level

  always_comb begin
    case (rec_src)
      REC_TIMER: rec_trig = rec_timer_tick;
      REC_EXTERNAL: rec_trig = sw_in.rec_ext && !rec_d1_q;
      REC_KEY: rec_trig = cmd_rec_key;
      default: rec_trig = 1'b0;
    endcase
  end

  wire rec_go = rec_en && rec_trig && series_cnt_q != 14'(SERIES_MAX);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rec_d1_q <= 1'b0;
      series_cnt_q <= 14'h0;
      spc_cnt_q <= 10'h0;
      record_strobe <= 1'b0;
      spc_push <= 1'b0;
    end else begin
      rec_d1_q <= sw_in.rec_ext;
      record_strobe <= rec_go;
      spc_push <= spc_en && sample_valid;
      if (cmd_series_clr || series_start) series_cnt_q <= 14'h0;
      else if (rec_go) series_cnt_q <= series_cnt_q + 14'h1;
      if (spc_en && sample_valid && spc_cnt_q != 10'(SPC_MAX))
        spc_cnt_q <= spc_cnt_q + 10'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    case (req.addr)
      REG_CTRL: rd_mux = ctrl_q;
      REG_LIMIT_HI: rd_mux = lim_hi_q;
      REG_LIMIT_LO: rd_mux = lim_lo_q;
      REG_IDLE: rd_mux = {25'h0, idle_q};
      REG_DTG_OUT: rd_mux = {30'h0, dtg_q};
      REG_STATUS: rd_mux = {25'h0, frozen_q, blank_off_q, blank_q, out_q};
      REG_SHOWN: rd_mux = shown_value;
      REG_SERIES: rd_mux = {18'h0, series_cnt_q};
      REG_SPC: rd_mux = {22'h0, spc_cnt_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) rdata <= 32'h0000_0000;
    else rdata <= req.rd ? rd_mux : 32'h0000_0000;
  end

endmodule : swio_display_hold

/* File: sim/swio_display_hold_properties.sv */
// Purpose: port-level timing checks for the switching i/o block
// Assumes: limits and ctrl mirrored from the write port; sync active-low reset
// Notes: limit checks look two edges back, the sample stage then the output stage
`timescale 1ns/100ps
module swio_display_hold_properties #(
  parameter int unsigned MIN_PULSE = swio_pkg::MIN_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire swio_pkg::reg_req_t req,
  input wire logic [6:0] rx_char,
  input wire logic rx_valid,
  input wire logic fault_detect,
  input wire logic signed [31:0] axis1_value,
  input wire swio_pkg::sw_in_t sw_in,
  input wire swio_pkg::sw_out_t sw_out,
  input wire logic output_event
);
  import swio_pkg::*;
  // write decodes seen on the port
  wire logic cmd = req.wr && req.addr == REG_CMD;
  wire logic ack = cmd && req.wdata[CMD_FAULT_ACK];
  wire logic prt = cmd && req.wdata[CMD_PRINT];
  wire logic ctlb = rx_valid && rx_char == ASCII_CTRL_B;
  logic [31:0] ctrl_q;  // mirrored ctrl
  logic signed [31:0] hi_q;  // mirrored limits
  logic signed [31:0] lo_q;
  logic [31:0] cnt_a_q;  // high-time counters
  logic [31:0] cnt_b_q;
  logic [31:0] cnt_z_q;
  logic ack_q;  // ack seen since last fault report
  //////////////////////////////////////////////
  // mirrors and counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      hi_q <= LIMIT_RESET;
      lo_q <= LIMIT_RESET;
      cnt_a_q <= '0;
      cnt_b_q <= '0;
      cnt_z_q <= '0;
      ack_q <= 1'b0;
    end else begin
      if (req.wr && req.addr == REG_CTRL) ctrl_q <= req.wdata;
      if (req.wr && req.addr == REG_LIMIT_HI) hi_q <= req.wdata;
      if (req.wr && req.addr == REG_LIMIT_LO) lo_q <= req.wdata;
      cnt_a_q <= sw_out.at_or_above_limit ? cnt_a_q + 32'h1 : '0;
      cnt_b_q <= sw_out.at_or_below_limit ? cnt_b_q + 32'h1 : '0;
      cnt_z_q <= sw_out.zero ? cnt_z_q + 32'h1 : '0;
      // a new fault report needs a fresh ack
      if (fault_detect) ack_q <= 1'b0;
      else if (ack) ack_q <= 1'b1;
    end
  end
  //////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_event_src;
    $rose(sw_in.latch) || ctlb || prt |=> output_event;
  endproperty
  a_event_src: assert property (p_event_src)
    else $error("output event missing");
  property p_event_cause;
    output_event |-> ($past(sw_in.latch) && !$past(sw_in.latch, 2)) || $past(ctlb || prt);
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("output event without source");
  property p_min_hold_above;
    $fell(sw_out.at_or_above_limit) |-> cnt_a_q >= MIN_PULSE;
  endproperty
  a_min_hold_above: assert property (p_min_hold_above)
    else $error("upper output too short");
  property p_min_hold_below;
    $fell(sw_out.at_or_below_limit) |-> cnt_b_q >= MIN_PULSE;
  endproperty
  a_min_hold_below: assert property (p_min_hold_below)
    else $error("lower output too short");
  property p_min_hold_zero;
    $fell(sw_out.zero) |-> cnt_z_q >= MIN_PULSE;
  endproperty
  a_min_hold_zero: assert property (p_min_hold_zero)
    else $error("zero output too short");
  property p_fault_set;
    fault_detect |=> ##[0:2] sw_out.fault;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault output not raised");
  property p_fault_hold;
    $fell(sw_out.fault) |-> ack_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault output dropped without ack");
  property p_above_cause;
    $rose(sw_out.at_or_above_limit) && !$past(ctrl_q[CTRL_DTG], 2)
      |-> $past(axis1_value, 2) >= $past(hi_q, 2);
  endproperty
  a_above_cause: assert property (p_above_cause)
    else $error("upper output below limit");
  property p_below_cause;
    $rose(sw_out.at_or_below_limit) && !$past(ctrl_q[CTRL_DTG], 2)
      |-> $past(axis1_value, 2) <= $past(lo_q, 2);
  endproperty
  a_below_cause: assert property (p_below_cause)
    else $error("lower output above limit");
  property p_thr_gate;
    $rose(sw_out.at_or_above_limit) || $rose(sw_out.at_or_below_limit)
      |-> $past(ctrl_q[CTRL_THR_EN], 2);
  endproperty
  a_thr_gate: assert property (p_thr_gate)
    else $error("threshold output while disabled");
  c_event: cover property (output_event);
  c_fault_clear: cover property ($fell(sw_out.fault));
  c_above: cover property ($rose(sw_out.at_or_above_limit));
endmodule : swio_display_hold_properties

bind swio_display_hold swio_display_hold_properties #(.MIN_PULSE(MIN_PULSE)) u_props (
  .clk(clk), .rst_n(rst_n), .req(req), .rx_char(rx_char), .rx_valid(rx_valid),
  .fault_detect(fault_detect), .axis1_value(axis1_value), .sw_in(sw_in),
  .sw_out(sw_out), .output_event(output_event)
);

/* File: sim/swio_controller.sv */
// Purpose: automation controller model driving the switching inputs
// Assumes: bench requests pin levels; the model drives them one edge later
// Notes: enable is held high for the whole stretch where version one control is used
`timescale 1ns/100ps
module swio_controller (
  input wire logic clk,
  input wire logic [4:0] sel,
  input wire logic enable,
  input wire logic latch,
  input wire logic rec,
  output swio_pkg::sw_in_t sw_in
);
  import swio_pkg::*;
  // idle pins, enable released
  initial sw_in = 7'h20;
  //////////////////////////////////////////////
  // pins change only after an edge, like a real output stage
  always @(posedge clk) begin
    sw_in.pin5 <= sel[0];
    sw_in.pin6_n <= !(sel[1] || enable);
    sw_in.pin7 <= sel[2];
    sw_in.pin8 <= sel[3];
    sw_in.pin9 <= sel[4];
    sw_in.latch <= latch;
    sw_in.rec_ext <= rec;
  end
endmodule : swio_controller

/* File: sim/tb.sv */
// Purpose: self-checking bench for the switching i/o and display hold block
// Assumes: short counts: 20-cycle pulse, 4 cycles a ms, 3 ms a minute
// Notes: idle blanking therefore comes after 30 * 12 = 360 quiet cycles
`timescale 1ns/100ps
module tb;
  import swio_pkg::*;
  localparam int unsigned MP = 20;
  logic clk = 0;
  logic rst_n = 0;
  reg_req_t req = '0;
  logic [31:0] rdata;
  sw_in_t sw_in;
  sw_out_t sw_out;
  logic signed [31:0] ax1 = 32'h0000_000B;
  logic sv = 1;  // a fresh sample every cycle
  logic activity = 1;
  logic fault_detect = 0;
  logic [6:0] rx_char = 7'h00;
  logic rx_valid = 0;
  logic tick = 0;
  logic [4:0] sel = 5'h00;
  logic enable = 0;
  logic latch = 0;
  logic rec = 0;
  logic signed [31:0] shown_value;
  logic display_on;
  logic output_event;
  logic series_start;
  logic rec_strobe;
  logic spc_push;
  int starts = 0;
  int recs = 0;
  int mismatches = 0;
  int comparisons = 0;
  // version one (enabled) then version two selections and views
  logic [4:0] sel_tab [10] = '{5'h04, 5'h08, 5'h10, 5'h00, 5'h0C,
                               5'h02, 5'h04, 5'h08, 5'h10, 5'h01};
  logic [31:0] exp_tab [10] = '{32'hFFFF_FFFD, 32'h9, 32'hC, 32'hB, 32'hB,
                                32'hB, 32'h4, 32'hF, 32'h7, 32'h4D};
  swio_display_hold #(.MIN_PULSE(MP), .MS_TICK(4), .MIN_TICK(3)) u_swio_display_hold (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .sw_in(sw_in), .sw_out(sw_out),
    .axis1_value(ax1), .axis2_value(32'sh4), .func_value(32'sh4D),
    .live_min(-32'sh3), .live_max(32'sh9), .sample_valid(sv), .activity(activity),
    .fault_detect(fault_detect), .rx_char(rx_char), .rx_valid(rx_valid),
    .rec_timer_tick(tick), .shown_value(shown_value), .display_on(display_on),
    .output_event(output_event), .series_start(series_start), .record_strobe(rec_strobe),
    .spc_push(spc_push)
  );
  swio_controller u_swio_controller (
    .clk(clk), .sel(sel), .enable(enable), .latch(latch), .rec(rec), .sw_in(sw_in)
  );
  initial forever #20 clk = ~clk;
  // count series starts as they happen, a pulse is easy to miss
  always @(posedge clk) if (series_start === 1'b1) starts++;
  always @(posedge clk) if (rec_strobe === 1'b1) recs++;
  //////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////
  // watchdog, the tests need about 12600 cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    step(4);
    rst_n <= 1;
    ax1 <= 32'sd100;
    wr(REG_LIMIT_HI, 32'h64);
    wr(REG_LIMIT_LO, 32'hFFFF_FF9C);
    wr(REG_CTRL, 32'h1);
    step(4);
    check({28'h0, sw_out}, 32'hA);
    ax1 <= -32'sd100;
    step(4);
    check({28'h0, sw_out}, 32'hE);
    step(MP + 5);
    check({28'h0, sw_out}, 32'h4);
    wr(REG_CTRL, 32'h0);
    ax1 <= 32'sd200;
    step(MP + 5);
    check({28'h0, sw_out}, 32'h0);
    ax1 <= 32'sd0;
    step(4);
    check({28'h0, sw_out}, 32'h2);
    ax1 <= 32'sd5;
    wr(REG_CTRL, 32'h3);
    wr(REG_DTG_OUT, 32'h2);
    step(MP + 5);
    check({28'h0, sw_out}, 32'h8);
    wr(REG_DTG_OUT, 32'h1);
    step(MP + 5);
    check({28'h0, sw_out}, 32'h4);
    wr(REG_CTRL, 32'h0);
    fault_detect <= 1;
    step(1);
    fault_detect <= 0;
    step(MP + 5);
    check({28'h0, sw_out}, 32'h1);
    wr(REG_CMD, 32'h2);
    step(MP + 5);
    check({28'h0, sw_out}, 32'h0);
    $display("test switching outputs done");
    wr(REG_CTRL, 32'h8);
    latch <= 1;
    step(3);
    latch <= 0;
    step(4);
    check(shown_value, 32'h5);
    ax1 <= 32'sd7;
    step(5);
    check(shown_value, 32'h5);
    wr(REG_CMD, 32'h1);
    step(4);
    check(shown_value, 32'h7);
    ax1 <= 32'sd8;
    rx_char <= ASCII_CTRL_B;
    rx_valid <= 1;
    step(1);
    rx_valid <= 0;
    step(4);
    check(shown_value, 32'h8);
    wr(REG_CTRL, 32'h4);
    latch <= 1;
    step(4);
    ax1 <= 32'sd9;
    step(5);
    check(shown_value, 32'h8);
    latch <= 0;
    step(5);
    check(shown_value, 32'h9);
    wr(REG_CTRL, 32'h0);
    latch <= 1;
    step(4);
    ax1 <= 32'sd3;
    step(5);
    check(shown_value, 32'h3);
    latch <= 0;
    $display("test display hold done");
    ax1 <= 32'sd11;
    sel <= 5'h04;
    wr(REG_CTRL, 32'h40);
    step(6);
    check(shown_value, 32'h9);
    for (int i = 0; i < 10; i++) begin
      if (i == 5) wr(REG_CTRL, 32'h10);
      sel <= sel_tab[i];
      enable <= (i < 5);
      step(6);
      check(shown_value, exp_tab[i]);
    end
    wr(REG_CTRL, 32'h0);
    sel <= 5'h00;
    enable <= 1;
    step(4);
    sel <= 5'h01;
    step(2);
    sel <= 5'h00;
    step(4);
    check(32'(starts), 32'h1);
    enable <= 0;
    step(3);
    sel <= 5'h01;
    step(2);
    sel <= 5'h00;
    step(4);
    check(32'(starts), 32'h1);
    $display("test input versions done");
    activity <= 0;
    wr(REG_IDLE, 32'h0);
    rd(REG_IDLE, 32'h1E);
    wr(REG_IDLE, 32'hC8);
    rd(REG_IDLE, 32'h78);
    wr(REG_IDLE, 32'h1E);
    step(340);
    check({31'h0, display_on}, 32'h1);
    step(40);
    check({31'h0, display_on}, 32'h0);
    wr(REG_CMD, 32'h4);
    step(400);
    check({31'h0, display_on}, 32'h1);
    rst_n <= 0;
    step(4);
    rst_n <= 1;
    rd(REG_CTRL, 32'h0);
    rd(REG_LIMIT_HI, 32'h0);
    rd(REG_STATUS, 32'h2);
    step(400);
    check({31'h0, display_on}, 32'h0);
    activity <= 1;
    step(4);
    check({31'h0, display_on}, 32'h1);
    $display("test idle blanking done");
    for (int s = 0; s < 3; s++) begin
      wr(REG_CTRL, 32'h200 | (32'(s) << 7));
      if (s == 0) tick <= 1;
      if (s == 1) rec <= 1;
      if (s == 2) wr(REG_CMD, 32'h8);
      step(1);
      tick <= 0;
      rec <= 0;
      step(4);
      rd(REG_SERIES, 32'(s + 1));
    end
    wr(REG_CTRL, 32'h200);
    tick <= 1;
    step(10010);
    tick <= 0;
    step(4);
    rd(REG_SERIES, 32'h2710);
    check(32'(recs), 32'h2710);
    wr(REG_CMD, 32'h10);
    rd(REG_SERIES, 32'h0);
    $display("test series recording done");
    wr(REG_CTRL, 32'h400);
    step(1005);
    check({31'h0, spc_push}, 32'h1);
    rd(REG_SPC, 32'h3E8);
    $display("test statistical control done");
    report_and_stop();
  end
endmodule : tb
